// ===== src/rip_top.sv
/*
   Reset generation and fixed-priority interrupt vectoring for a small core.
   Assumes the core raises ack for one cycle while irq_request is high, and that all
   peripheral pulses are synchronous to clk_sys; pins are synchronised here.
*/
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// (R1) Four reset sources; malfunction resets last at most 24 fc periods.
// (R2) Malfunction detector starts loaded, so power-on gives one spurious short reset.
// (R3) Reset loads reset vector, clears enables, latches, prescaler; enables watchdog.
// (R4) Reset pin low at least three machine cycles applies reset.
// (R5) Reset pin high releases reset; execution starts at the reset vector.
// (R6) Fetch in register area, or RAM when selected, raises address trap.
// (R7) Address trap resets by default; select bit zero makes it an interrupt.
// (R8) Watchdog overflow resets by default; select bit zero makes it an interrupt.
// (R9) Illegal oscillator-enable clears cause a clock reset; oscillators keep running. The ensuing reset here reloads RST_SYSCLK, which clears lf_osc_enable.
// (R10) Seventeen sources, four non-maskable, accepted in fixed hardware order.
// (R11) Request sets its latch; maskable needs master and own enable.
// (R12) Reset FFFE, software/undefined FFFC unlatched, trap latch 2, watchdog latch 3.
// (R13) Latches 4 to 15 pair with enables; vectors descend by two; pin enable.
// (R14) Latch 11 serves timer four or external three by select bit.
// (R15) Accepting an interrupt clears its latch at once.
// (R16) Acceptance stacks master enable then clears it; return restores it.
// (R17) Any reset request beats pending interrupts and clears latches first.
module rip_top
   import rip_pkg::*;
#(
   parameter logic [15:0] SFR_FIRST = 16'h0000,
   parameter logic [15:0] SFR_LAST  = 16'h003F,
   parameter logic [15:0] RAM_FIRST = 16'h0040,
   parameter logic [15:0] RAM_LAST  = 16'h023F
) (
   // Clock and reset.
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // External reset pin.
   input  wire logic              reset_pin_b,
   // Register port.
   input  wire rip_bus_s          bus_req,
   output logic [DATA_W-1:0]      bus_rdata,
   // Fetch monitor and watchdog.
   input  wire logic              fetch_valid,
   input  wire logic [15:0]       fetch_addr,
   input  wire logic              watchdog_overflow,
   // Interrupt sources.
   input  wire logic              software_irq,
   input  wire logic              undefined_opcode_irq,
   input  wire logic [PER_W-1:0]  periph_irq,
   input  wire logic [EXT_W-1:0]  ext_irq_pin,
   // Core side.
   input  wire rip_cpu_s          cpu_in,
   output logic                   irq_request,
   output logic [15:0]            irq_vector,
   output logic                   stacked_imf,
   // Reset and clock outputs.
   output logic                   core_reset,
   output logic                   prescaler_clear,
   output logic                   watchdog_enable,
   output logic                   hf_osc_enable,
   output logic                   lf_osc_enable,
   output logic                   clock_select,
   // Event interrupt.
   output logic                   event_irq
);

   // Lowest set index wins; index 1 stands for the unlatched software source.
   function automatic logic [IDX_W:0] first_set(input logic [NUM_LATCH-1:0] v);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = NUM_LATCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction

   // Vector of an index, descending by two from the top.
   function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
      return VECTOR_TOP - {11'h000, idx, 1'b0};
   endfunction

   logic [5:0]            sync1_reg;
   logic [5:0]            sync2_reg;
   logic [EXT_W-1:0]      ext_prev_reg;
   logic [CNT_W-1:0]      lo_cnt_reg;
   logic                  pin_lo;
   logic                  ext_rst;
   logic                  malf_active;
   logic                  malf_trig;
   logic                  reset_req;
   logic [NUM_LATCH-1:0]  latch_reg;
   logic [NUM_LATCH-1:0]  en_reg;
   logic                  imf_reg;
   logic                  stacked_reg;
   logic [DATA_W-1:0]     trap_wdt_reg;
   logic [DATA_W-1:0]     src_sel_reg;
   logic [DATA_W-1:0]     sysclk_reg;
   logic [EVT_W-1:0]      evt_reg;
   logic [EVT_W-1:0]      mask_reg;
   logic [DATA_W-1:0]     rdata_reg;
   logic [EXT_W-1:0]      ext_edge;
   logic                  trap_hit;
   logic                  clk_fault;
   logic                  sysclk_wr;
   logic [NUM_LATCH-1:0]  set_vec;
   logic [NUM_LATCH-1:0]  clr_vec;
   logic [NUM_LATCH-1:0]  pending;
   logic [IDX_W:0]        pick;
   logic                  accept;
   logic                  ext_rst_prev_reg;

   // Pins pass two flops; only the second stage feeds logic.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= 6'h3F;
         sync2_reg <= 6'h3F;
         ext_prev_reg <= '1;
      end else begin
         sync1_reg <= {reset_pin_b, ext_irq_pin};
         sync2_reg <= sync1_reg;
         ext_prev_reg <= sync2_reg[EXT_W-1:0];
      end
   end

   // External interrupts are taken on the rising edge of the synchronised pin.
   assign ext_edge = sync2_reg[EXT_W-1:0] & ~ext_prev_reg;
   assign pin_lo = !sync2_reg[5];

   // The pin must stay low the full hold time before reset is applied.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lo_cnt_reg <= '0;
      end else if (!pin_lo) begin
         lo_cnt_reg <= '0; // R5
      end else if (lo_cnt_reg != CNT_W'(EXT_RST_CYCLES)) begin
         lo_cnt_reg <= lo_cnt_reg + 1'b1; // R4
      end
   end

   assign ext_rst = pin_lo && (lo_cnt_reg == CNT_W'(EXT_RST_CYCLES)); // R4

   // Malfunction detection from trap, watchdog and clock faults.
   assign trap_hit = fetch_valid &&
      ((fetch_addr >= SFR_FIRST && fetch_addr <= SFR_LAST) ||
       (trap_wdt_reg[BIT_RAM_TRAP_SEL] &&
        fetch_addr >= RAM_FIRST && fetch_addr <= RAM_LAST)); // R6
   assign sysclk_wr = bus_req.wr && (bus_req.addr == OFS_SYSCLK);
   assign clk_fault = sysclk_wr &&
      ((sysclk_reg[BIT_HF_EN] && sysclk_reg[BIT_LF_EN] &&
        !bus_req.wdata[BIT_HF_EN] && !bus_req.wdata[BIT_LF_EN]) ||
       (sysclk_reg[BIT_HF_EN] && !bus_req.wdata[BIT_HF_EN] && !bus_req.wdata[BIT_SYSCK]) ||
       (sysclk_reg[BIT_LF_EN] && !bus_req.wdata[BIT_LF_EN] && bus_req.wdata[BIT_SYSCK])); // R9
   assign malf_trig = (trap_hit && trap_wdt_reg[BIT_TRAP_OUT_SEL]) || // R7
                      (watchdog_overflow && trap_wdt_reg[BIT_WDT_OUT_SEL]) || // R8
                      clk_fault; // R9

   rip_pulse #(
      .CYCLES (MALF_CYCLES)
   ) u_pulse (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .trigger (malf_trig),
      .active  (malf_active)
   );

   assign core_reset = ext_rst || malf_active; // R1
   assign reset_req = core_reset || malf_trig; // R17
   assign prescaler_clear = core_reset; // R3

   // Request sources into latch positions; bit 1 is the unlatched software level.
   always_comb begin
      set_vec = '0;
      set_vec[IDX_TRAP] = trap_hit && !trap_wdt_reg[BIT_TRAP_OUT_SEL]; // R7
      set_vec[IDX_WDT] = watchdog_overflow && !trap_wdt_reg[BIT_WDT_OUT_SEL]; // R8
      set_vec[IDX_EXT0] = ext_edge[0]; // R11
      set_vec[5] = ext_edge[1];
      set_vec[6] = periph_irq[0];
      set_vec[7] = periph_irq[1];
      set_vec[8] = periph_irq[2];
      set_vec[9] = periph_irq[3];
      set_vec[10] = periph_irq[4];
      set_vec[IDX_SHARED] = src_sel_reg[BIT_LEVEL11_SEL] ? ext_edge[2] : periph_irq[5]; // R14
      set_vec[12] = periph_irq[6];
      set_vec[13] = periph_irq[7];
      set_vec[14] = ext_edge[3];
      set_vec[15] = ext_edge[4];
   end

   // Non-maskable sources pass alone; maskable ones need both enables.
   always_comb begin
      pending = latch_reg & en_reg & {NUM_LATCH{imf_reg}}; // R11
      pending[IDX_EXT0] = pending[IDX_EXT0] && src_sel_reg[BIT_EXT0_PIN_EN]; // R13
      pending[IDX_TRAP] = latch_reg[IDX_TRAP]; // R12
      pending[IDX_WDT] = latch_reg[IDX_WDT]; // R12
      pending[IDX_SOFT] = software_irq || undefined_opcode_irq; // R12
      pending[0] = 1'b0;
   end

   assign pick = first_set(pending); // R10
   assign irq_request = pick[IDX_W] && !reset_req; // R17
   assign irq_vector = core_reset ? RESET_VECTOR : vec_of(pick[IDX_W-1:0]); // R5 R13
   assign accept = cpu_in.ack && irq_request;

   // Clears from acceptance and from software zeros; a same-cycle request still sets.
   always_comb begin
      clr_vec = '0;
      if (accept) begin
         clr_vec[pick[IDX_W-1:0]] = 1'b1; // R15
      end
      if (bus_req.wr && bus_req.addr == OFS_LATCH) begin
         clr_vec = clr_vec | ~bus_req.wdata;
      end
   end

   // Request latches; reset clears them ahead of the vector fetch.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         latch_reg <= '0;
      end else if (core_reset) begin
         latch_reg <= '0; // R3 R17
      end else begin
         latch_reg <= ((latch_reg & ~clr_vec) | set_vec) & 16'hFFFC; // R11 R15
      end
   end

   // Master enable with stacking on acceptance and restore on return.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         imf_reg <= 1'b0;
         stacked_reg <= 1'b0;
      end else if (core_reset) begin
         imf_reg <= 1'b0; // R3
      end else if (accept) begin
         stacked_reg <= imf_reg; // R16
         imf_reg <= 1'b0; // R16
      end else if (cpu_in.reti) begin
         imf_reg <= cpu_in.reti_imf; // R16
      end else if (bus_req.wr && bus_req.addr == OFS_ENABLE) begin
         imf_reg <= bus_req.wdata[BIT_MASTER_EN];
      end
   end

   assign stacked_imf = stacked_reg;

   // Enables and control registers, returned to defaults by every reset.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         en_reg <= '0;
         trap_wdt_reg <= RST_TRAP_WDT;
         src_sel_reg <= '0;
         sysclk_reg <= RST_SYSCLK;
      end else if (core_reset) begin
         en_reg <= '0; // R3
         trap_wdt_reg <= RST_TRAP_WDT; // R3 R7 R8
         src_sel_reg <= '0;
         sysclk_reg <= RST_SYSCLK;
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            OFS_ENABLE: en_reg <= bus_req.wdata & 16'hFFF0; // R13
            OFS_TRAP_WDT: trap_wdt_reg <= bus_req.wdata & 16'h000F;
            OFS_SRC_SEL: src_sel_reg <= bus_req.wdata & 16'h0003;
            OFS_SYSCLK: begin
               if (!clk_fault) begin
                  sysclk_reg <= bus_req.wdata & 16'h00E0;
               end
            end
            default: ;
         endcase
      end
   end

   assign watchdog_enable = trap_wdt_reg[BIT_WDT_ENABLE]; // R3
   assign hf_osc_enable = sysclk_reg[BIT_HF_EN]; // R9
   assign lf_osc_enable = sysclk_reg[BIT_LF_EN];
   assign clock_select = sysclk_reg[BIT_SYSCK];

   // Reset-cause events survive internal resets so software can see why it restarted.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext_rst_prev_reg <= 1'b0;
         evt_reg <= '0;
         mask_reg <= '0;
      end else begin
         ext_rst_prev_reg <= ext_rst;
         if (bus_req.rd && bus_req.addr == OFS_EVT_STATUS) begin
            evt_reg <= '0;
         end
         if (trap_hit) begin
            evt_reg[EVT_TRAP] <= 1'b1;
         end
         if (watchdog_overflow) begin
            evt_reg[EVT_WDT] <= 1'b1;
         end
         if (clk_fault) begin
            evt_reg[EVT_CLKFAULT] <= 1'b1;
         end
         if (ext_rst && !ext_rst_prev_reg) begin
            evt_reg[EVT_EXTRST] <= 1'b1;
         end
         if (bus_req.wr && bus_req.addr == OFS_EVT_MASK) begin
            mask_reg <= bus_req.wdata[EVT_W-1:0];
         end
      end
   end

   assign event_irq = |(evt_reg & mask_reg);

   // Read data stand one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= '0;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            OFS_LATCH: rdata_reg <= latch_reg;
            OFS_ENABLE: rdata_reg <= en_reg | {15'h0000, imf_reg};
            OFS_TRAP_WDT: rdata_reg <= trap_wdt_reg;
            OFS_SRC_SEL: rdata_reg <= src_sel_reg;
            OFS_SYSCLK: rdata_reg <= sysclk_reg;
            OFS_EVT_STATUS: rdata_reg <= {12'h000, evt_reg};
            OFS_EVT_MASK: rdata_reg <= {12'h000, mask_reg};
            default: rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign bus_rdata = rdata_reg;

   // Checking helpers: run length of a malfunction pulse and the index picked in the previous cycle.
   logic [CNT_W-1:0] malf_run_reg;
   logic [IDX_W-1:0] ack_idx_reg;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         malf_run_reg <= '0;
         ack_idx_reg <= '0;
      end else begin
         malf_run_reg <= malf_active ? malf_run_reg + 1'b1 : '0;
         ack_idx_reg <= pick[IDX_W-1:0];
      end
   end

   a_malf_bounded: assert property (@(posedge clk_sys) disable iff (!rst_b)
      malf_run_reg <= CNT_W'(MALF_CYCLES)) // R1
      else $error("malfunction reset too long");
   a_poweron_spur: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(rst_b) |-> core_reset) // R2
      else $error("no power-on malfunction pulse");
   a_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
      core_reset |=> (latch_reg == '0 && en_reg == '0 && !imf_reg && watchdog_enable)) // R3
      else $error("reset left state uncleared");
   a_pin_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(ext_rst) |-> $past(pin_lo, 12)) // R4
      else $error("pin reset applied too early");
   a_pin_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!pin_lo && !malf_active) |-> (!core_reset && irq_vector != RESET_VECTOR ||
      !core_reset)) // R5
      else $error("reset held after pin release");
   a_reset_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
      core_reset |-> (irq_vector == 16'hFFFE && !irq_request)) // R17
      else $error("reset did not win");
   a_trap_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (trap_hit && !core_reset && !trap_wdt_reg[BIT_TRAP_OUT_SEL]) |=>
      (latch_reg[IDX_TRAP] && !malf_active)) // R7
      else $error("trap not routed to interrupt");
   a_wdt_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (watchdog_overflow && !malf_active && trap_wdt_reg[BIT_WDT_OUT_SEL]) |=>
      core_reset) // R8
      else $error("watchdog did not reset");
   a_clk_fault: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (clk_fault && !malf_active) |=> (core_reset && $stable(hf_osc_enable))) // R9
      else $error("clock fault handling wrong");
   a_mask_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (irq_request && pick[IDX_W-1:0] >= IDX_W'(IDX_FIRST_MASKABLE)) |->
      (imf_reg && en_reg[pick[IDX_W-1:0]])) // R11
      else $error("masked interrupt requested");
   a_ack_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (accept && pick[IDX_W-1:0] >= IDX_W'(IDX_TRAP) && !set_vec[pick[IDX_W-1:0]]) |=>
      !latch_reg[ack_idx_reg]) // R15
      else $error("accepted latch not cleared");
   a_imf_stack: assert property (@(posedge clk_sys) disable iff (!rst_b)
      accept |=> (!imf_reg && stacked_imf == $past(imf_reg))) // R16
      else $error("master enable not stacked");

   c_trap_irq: cover property (@(posedge clk_sys) disable iff (!rst_b)
      accept && pick[IDX_W-1:0] == IDX_W'(IDX_TRAP));
   c_clk_reset: cover property (@(posedge clk_sys) disable iff (!rst_b)
      clk_fault ##1 core_reset);
   c_shared_ext3: cover property (@(posedge clk_sys) disable iff (!rst_b)
      accept && src_sel_reg[BIT_LEVEL11_SEL] && pick[IDX_W-1:0] == IDX_W'(IDX_SHARED));
   c_nested_ret: cover property (@(posedge clk_sys) disable iff (!rst_b)
      accept ##[1:20] cpu_in.reti);

endmodule

// ===== src/rip_pkg.sv
/*
   Shared constants and carrier types for the reset and interrupt priority block.
   Assumes one 100 MHz system clock that also stands for the high-frequency clock.
*/
package rip_pkg;

   // Register port widths, latch count and index width.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int NUM_LATCH = 16;
   localparam int IDX_W = 4;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFS_LATCH = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_TRAP_WDT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_SRC_SEL = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_SYSCLK = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 4'h6;

   // Field positions.
   localparam int BIT_MASTER_EN = 0;
   localparam int BIT_RAM_TRAP_SEL = 0;
   localparam int BIT_TRAP_OUT_SEL = 1;
   localparam int BIT_WDT_OUT_SEL = 2;
   localparam int BIT_WDT_ENABLE = 3;
   localparam int BIT_LEVEL11_SEL = 0;
   localparam int BIT_EXT0_PIN_EN = 1;
   localparam int BIT_SYSCK = 5;
   localparam int BIT_LF_EN = 6;
   localparam int BIT_HF_EN = 7;
   localparam int EVT_TRAP = 0;
   localparam int EVT_WDT = 1;
   localparam int EVT_CLKFAULT = 2;
   localparam int EVT_EXTRST = 3;
   localparam int EVT_W = 4;

   // Latch indices and source positions.
   localparam int IDX_SOFT = 1;
   localparam int IDX_TRAP = 2;
   localparam int IDX_WDT = 3;
   localparam int IDX_EXT0 = 4;
   localparam int IDX_FIRST_MASKABLE = 4;
   localparam int IDX_SHARED = 11;
   localparam int PER_W = 8;
   localparam int EXT_W = 5;

   // Reset values.
   localparam logic [DATA_W-1:0] RST_TRAP_WDT = 16'h000E;
   localparam logic [DATA_W-1:0] RST_SYSCLK = 16'h0080;

   // Vectors.
   localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
   localparam logic [15:0] VECTOR_TOP = 16'hFFFE;

   // Timing: figures in high-frequency clock periods, then system clock cycles.
   localparam int SYS_CLK_MHZ = 100;
   localparam int FC_MHZ = 100;
   localparam int MALF_FC_PERIODS = 24;
   localparam int EXT_RST_FC_PERIODS = 12;
   localparam int MALF_CYCLES = MALF_FC_PERIODS * SYS_CLK_MHZ / FC_MHZ;
   localparam int EXT_RST_CYCLES = (EXT_RST_FC_PERIODS * SYS_CLK_MHZ + FC_MHZ - 1) / FC_MHZ;
   localparam int CNT_W = 6;

   // Register port request.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rip_bus_s;

   // Core acceptance and return signals.
   typedef struct packed {
      logic ack;
      logic reti;
      logic reti_imf;
   } rip_cpu_s;

endpackage

// ===== src/rip_pulse.sv
/*
   Malfunction reset stretcher: turns a one-cycle trigger into a bounded reset pulse.
   Assumes triggers are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module rip_pulse
   import rip_pkg::*;
#(
   parameter int CYCLES = MALF_CYCLES
) (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Trigger and pulse.
   input  wire logic trigger,
   output logic      active
);

   localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

   logic [CNT_W-1:0] cnt_reg;

   // The counter is not cleared at power-on; it starts loaded, so a full pulse follows.
   // A trigger during a pulse is ignored so no pulse outlasts the bound.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= LOAD; // R2
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1; // R1
      end else if (trigger) begin
         cnt_reg <= LOAD; // R1
      end
   end

   assign active = (cnt_reg != '0);

endmodule

// ===== dv/rip_core_model.sv
/*
   Behavioural core that accepts interrupts and returns from them.
   Assumes the block's request and vector settle before each rising edge.
*/
`timescale 1ns/1ps
module rip_core_model
   import rip_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Block side.
   input  wire logic        irq_request,
   input  wire logic [15:0] irq_vector,
   input  wire logic        stacked_imf,
   output rip_cpu_s         cpu_out,
   // Bench control.
   input  wire logic        stall,
   input  wire logic        do_reti,
   output logic [15:0]      last_vec,
   output int               n_ack
);
   // Ack lasts one cycle; stall models a long instruction that delays acceptance.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpu_out  <= '0;
         last_vec <= 16'h0000;
         n_ack    <= 0;
      end else begin
         cpu_out.ack      <= irq_request & ~cpu_out.ack & ~stall;
         cpu_out.reti     <= do_reti;
         cpu_out.reti_imf <= stacked_imf;
         if (cpu_out.ack && irq_request) begin
            last_vec <= irq_vector;
            n_ack    <= n_ack + 1;
         end
      end
   end
endmodule

// ===== dv/tb_reset_and_interrupt_priority.sv
/*
   Bench for the reset and interrupt priority block.
   Assumes the package and the block's design files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_reset_and_interrupt_priority
   import rip_pkg::*;
;
   logic              clk_sys, rst_b, reset_pin_b, fetch_valid, watchdog_overflow, stall;
   logic              software_irq, undefined_opcode_irq, do_reti, irq_request, stacked_imf;
   logic              core_reset, watchdog_enable, hf_osc_enable, event_irq;
   logic [15:0]       fetch_addr, irq_vector, last_vec;
   logic [DATA_W-1:0] bus_rdata;
   logic [PER_W-1:0]  periph_irq;
   logic [EXT_W-1:0]  ext_irq_pin;
   rip_bus_s          bus_req;
   rip_cpu_s          cpu_in;
   int                n_ack, errors, tests_run;

   rip_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .watchdog_overflow(watchdog_overflow),
      .software_irq(software_irq), .undefined_opcode_irq(undefined_opcode_irq),
      .periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin), .cpu_in(cpu_in),
      .irq_request(irq_request), .irq_vector(irq_vector), .stacked_imf(stacked_imf),
      .core_reset(core_reset), .prescaler_clear(), .watchdog_enable(watchdog_enable),
      .hf_osc_enable(hf_osc_enable), .lf_osc_enable(), .clock_select(),
      .event_irq(event_irq));
   rip_core_model u_core (.clk_sys(clk_sys), .rst_b(rst_b), .irq_request(irq_request),
      .irq_vector(irq_vector), .stacked_imf(stacked_imf), .cpu_out(cpu_in),
      .stall(stall), .do_reti(do_reti), .last_vec(last_vec), .n_ack(n_ack));

   // Free-running 100 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input bit c = 1);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      if (c) `CHK("rdata", e, bus_rdata)
   endtask

   // One-cycle event strobes: peripheral pulses, a fetch, a watchdog overflow.
   task automatic kick(input logic [PER_W-1:0] p, input logic f, input logic [15:0] a,
                       input logic w);
      @(posedge clk_sys);
      periph_irq        <= p;
      fetch_valid       <= f;
      fetch_addr        <= a;
      watchdog_overflow <= w;
      @(posedge clk_sys);
      periph_irq        <= '0;
      fetch_valid       <= 1'b0;
      watchdog_overflow <= 1'b0;
   endtask

   task automatic exp_irq(input logic [15:0] v);
      int k;
      k = n_ack;
      for (int i = 0; i < 30 && n_ack == k; i++) @(posedge clk_sys);
      #1;
      `CHK("acks", k + 1, n_ack)
      `CHK("vector", v, last_vec)
   endtask

   task automatic no_irq();
      int k;
      k = n_ack;
      repeat (12) @(posedge clk_sys);
      `CHK("no_ack", k, n_ack)
   endtask

   // Measures the internal reset pulse in whole cycles; lo is the shortest allowed.
   task automatic pulse_len(input int lo);
      int n;
      n = 0;
      #1;
      while (core_reset && n < 100) begin
         #10;
         n++;
      end
      `CHK("pulse_ok", 1'b1, n >= lo && n <= MALF_CYCLES)
   endtask

   // Watchdog: the whole sequence needs a few hundred cycles.
   initial begin
      #100000;
      errors++;
      finish_test();
   end

   // Main sequence.
   initial begin
      rst_b = 1'b0; reset_pin_b = 1'b1; bus_req = '0; fetch_valid = 1'b0;
      fetch_addr = 16'h0100; watchdog_overflow = 1'b0; software_irq = 1'b0;
      undefined_opcode_irq = 1'b0; periph_irq = '0; ext_irq_pin = '0;
      stall = 1'b0; do_reti = 1'b0; errors = 0; tests_run = 0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1 `CHK("core_reset", 1'b1, core_reset)
      `CHK("vector", RESET_VECTOR, irq_vector)
      `CHK("wdt_en", 1'b1, watchdog_enable)
      pulse_len(0);
      rd(OFS_TRAP_WDT, RST_TRAP_WDT);
      rd(OFS_SYSCLK, RST_SYSCLK);
      rd(OFS_ENABLE, 16'h0000);
      rd(OFS_LATCH, 16'h0000);
      rd(4'hF, 16'h0000);
      rd(OFS_EVT_STATUS, 16'h0000, 0);
      wr(OFS_EVT_MASK, 16'h0008);
      // Two maskable requests at once while the core stalls.
      wr(OFS_ENABLE, 16'h00C1);
      stall <= 1'b1;
      kick(8'h03, 1'b0, 16'h0100, 1'b0);
      rd(OFS_LATCH, 16'h00C0);
      `CHK("vector", 16'hFFF2, irq_vector)
      stall <= 1'b0;
      exp_irq(16'hFFF2);
      rd(OFS_LATCH, 16'h0080);
      rd(OFS_ENABLE, 16'h00C0);
      `CHK("stacked", 1'b1, stacked_imf)
      @(posedge clk_sys) do_reti <= 1'b1;
      @(posedge clk_sys) do_reti <= 1'b0;
      exp_irq(16'hFFF0);
      // Shared level: the select bit picks timer four or pin three.
      wr(OFS_ENABLE, 16'h0801);
      ext_irq_pin <= 5'h04;
      no_irq();
      kick(8'h20, 1'b0, 16'h0100, 1'b0);
      exp_irq(16'hFFE8);
      ext_irq_pin <= 5'h00;
      wr(OFS_SRC_SEL, 16'h0001);
      wr(OFS_ENABLE, 16'h0801);
      ext_irq_pin <= 5'h04;
      exp_irq(16'hFFE8);
      // Pin zero needs its own pin enable on top of the flags.
      wr(OFS_ENABLE, 16'h0011);
      ext_irq_pin <= 5'h01;
      no_irq();
      wr(OFS_SRC_SEL, 16'h0002);
      exp_irq(16'hFFF6);
      // Trap and watchdog routed to interrupts.
      wr(OFS_TRAP_WDT, 16'h0008);
      kick(8'h00, 1'b1, 16'h0010, 1'b0);
      exp_irq(16'hFFFA);
      kick(8'h00, 1'b0, 16'h0100, 1'b1);
      exp_irq(16'hFFF8);
      kick(8'h00, 1'b1, 16'h0100, 1'b0);
      no_irq();
      wr(OFS_TRAP_WDT, 16'h0009);
      kick(8'h00, 1'b1, 16'h0100, 1'b0);
      exp_irq(16'hFFFA);
      // Unlatched requests are held high by the bench until accepted.
      software_irq <= 1'b1;
      exp_irq(16'hFFFC);
      software_irq <= 1'b0;
      undefined_opcode_irq <= 1'b1;
      exp_irq(16'hFFFC);
      undefined_opcode_irq <= 1'b0;
      // Leave a latch pending, then reset from the pin.
      kick(8'h01, 1'b0, 16'h0100, 1'b0);
      reset_pin_b <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1 `CHK("core_reset", 1'b1, core_reset)
      `CHK("vector", RESET_VECTOR, irq_vector)
      `CHK("evt_irq", 1'b1, event_irq)
      reset_pin_b <= 1'b1;
      for (int i = 0; i < 10 && core_reset; i++) @(posedge clk_sys);
      `CHK("core_reset", 1'b0, core_reset)
      rd(OFS_LATCH, 16'h0000);
      rd(OFS_TRAP_WDT, RST_TRAP_WDT);
      rd(OFS_EVT_STATUS, 16'h0000, 0);
      `CHK("evt_irq", 1'b0, event_irq)
      // Malfunction resets: trap, watchdog, clock fault.
      kick(8'h00, 1'b1, 16'h0010, 1'b0);
      pulse_len(MALF_CYCLES);
      kick(8'h00, 1'b0, 16'h0100, 1'b1);
      pulse_len(MALF_CYCLES);
      wr(OFS_SYSCLK, 16'h0000);
      pulse_len(MALF_CYCLES);
      `CHK("hf_en", 1'b1, hf_osc_enable)
      finish_test();
   end
endmodule
